// >>> aip_pkg.sv
// Purpose: shared constants and types of the two-wire slave port.
// Assumes: one system clock at CLK_HZ; bus logic on its own lclk.
// Notes:   every figure the port logic uses is named here.
package aip_pkg;
	// ==========================================================
	// timing
	// system clock rate
	localparam int unsigned CLK_HZ = 25000000;
	// bus idle limit in its own unit
	localparam int unsigned TIMEOUT_MS = 25;
	// idle limit in mclk cycles
	localparam int unsigned TIMEOUT_CYC_DEF = TIMEOUT_MS * (CLK_HZ / 1000);
	// timeout counter width, holds the default count
	localparam int unsigned TO_W = 20;
	// ==========================================================
	// addressing
	// answer address with select pin low
	localparam logic [6:0] SLAVE_ADDR_LO = 7'h48;
	// answer address with select pin high
	localparam logic [6:0] SLAVE_ADDR_HI = 7'h49;
	// byte and pointer layout
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned PTR_W = 5;
	localparam int unsigned PTR_INC_BIT = 7;
	localparam int unsigned RW_BIT = 0;
	localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;
	localparam logic [PTR_W-1:0] PTR_ONE = 5'h01;
	// mode control register and its mode field
	localparam logic [PTR_W-1:0] MODE_REG_ADDR = 5'h00;
	localparam int unsigned MODE_LSB = 2;
	localparam int unsigned MODE_W = 6;
	// ==========================================================
	// bit counting and line idle levels
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [2:0] SYNC_IDLE = 3'h7;
	// ==========================================================
	// bus engine states
	typedef enum logic [3:0]
	{
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_PTR,
		ST_PTR_ACK,
		ST_WDATA,
		ST_WACK,
		ST_RDATA,
		ST_RACK,
		ST_IGNORE
	} aip_state_t;
endpackage

// >>> aip_link_if.sv
// Purpose: carries bus events from the line front end to the engine.
// Assumes: all signals are on lclk.
// Notes:   events are one lclk cycle wide.
`timescale 1ns/100ps
interface aip_link_if;
	// clock line edges
	logic scl_rise;
	logic scl_fall;
	// start and stop conditions
	logic start_det;
	logic stop_det;
	// synchronised data line level
	logic sda_lvl;
	modport front (output scl_rise, output scl_fall, output start_det,
		output stop_det, output sda_lvl);
	modport engine (input scl_rise, input scl_fall, input start_det,
		input stop_det, input sda_lvl);
endinterface

// >>> aip_front.sv
// Purpose: synchronises both bus lines and finds edges and conditions.
// Assumes: lclk samples many times per bus clock period.
// Notes:   first sync stage feeds only the second.
`timescale 1ns/100ps
module aip_front
(
	input wire logic lclk,
	input wire logic lrst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	aip_link_if.front lk
);
	import aip_pkg::*;

	// ==========================================================
	// synchronisers
	// stage 0 and 1 synchronise, stage 2 is a delayed copy
	logic [2:0] scl_s_q;
	logic [2:0] sda_s_q;

	// shift both lines in; released lines idle high
	// [RULE21] oversampling keeps up with 400 kHz clocks
	always_ff @(posedge lclk or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			scl_s_q <= SYNC_IDLE;
			sda_s_q <= SYNC_IDLE;
		end
		else
		begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
		end
	end

	// ==========================================================
	// event decode
	assign lk.scl_rise = scl_s_q[1] & ~scl_s_q[2];
	assign lk.scl_fall = ~scl_s_q[1] & scl_s_q[2];
	// [RULE5] data falling while clock high
	assign lk.start_det = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
	// [RULE6] data rising while clock high
	assign lk.stop_det = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];
	assign lk.sda_lvl = sda_s_q[1];
endmodule

// >>> aip_slave_port.sv
// Purpose: slave-only two-wire serial port of a four-channel monitor;
//          bridges bus transfers to the register file on mclk.
// Assumes: lclk runs free and far faster than the bus clock; the
//          register file answers reg_rdata combinationally on reg_addr.
// Notes:   bus engine on lclk, register side and timeout on mclk.
// Function
// [RULE1] slave only: clock is input, never starts
// [RULE2] lines pulled low or released, never high
// [RULE3] eight-bit units, each followed by acknowledge
// [RULE4] data changes while clock low, sampled high
// [RULE5] data fall with clock high is start
// [RULE6] data rise with clock high is stop
// [RULE7] start during transfer restarts address reception
// [RULE8] bus idle past 25 ms aborts transfer
// [RULE9] master sends 7-bit address plus direction
// [RULE10] device acknowledges written bytes on ninth pulse
// [RULE11] device drives read bytes, master acknowledges
// [RULE12] high acknowledge is nack, ends reading
// [RULE13] device drives data only when read
// [RULE14] address 1001000 or 1001001 by select pin
// [RULE15] select pin sampled continuously, never latched
// [RULE16] mode starts at acknowledge trailing edge
// [RULE17] address mismatch: no acknowledge, wait for start
// [RULE18] write transfer carries pointer byte first
// [RULE19] pointer top bit increments, low five select
// [RULE20] pointer kept between transactions
// [RULE21] works with bus clocks up to 400 kHz
`timescale 1ns/100ps
module aip_slave_port
#(
	parameter int unsigned TIMEOUT_CYC = aip_pkg::TIMEOUT_CYC_DEF
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic lclk,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic address_select_pin,
	output logic reg_wr,
	output logic reg_rd,
	output logic [aip_pkg::PTR_W-1:0] reg_addr,
	output logic [aip_pkg::BYTE_W-1:0] reg_wdata,
	input wire logic [aip_pkg::BYTE_W-1:0] reg_rdata,
	output logic mode_start,
	output logic [aip_pkg::MODE_W-1:0] mode_val,
	output logic bus_timeout
);
	import aip_pkg::*;

	// ==========================================================
	// link reset and front end
	// reset for lclk: asserts at once, releases on lclk
	logic lrst_s_q;
	logic lrst_n;
	// events from the front end
	aip_link_if lk();

	// reset synchroniser for the bus domain
	always_ff @(posedge lclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lrst_s_q <= 1'b0;
			lrst_n <= 1'b0;
		end
		else
		begin
			lrst_s_q <= 1'b1;
			lrst_n <= lrst_s_q;
		end
	end

	aip_front u_front
	(
		.lclk(lclk),
		.lrst_n(lrst_n),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.lk(lk.front)
	);

	// ==========================================================
	// bus engine (lclk)
	aip_state_t state_q;
	aip_state_t state_d;
	logic [3:0] cnt_q; // clock rises seen in this unit
	logic [BYTE_W-1:0] shift_q; // received byte
	logic [BYTE_W-1:0] tx_q; // byte being sent
	logic rw_q; // direction bit of the address
	logic nack_q; // master acknowledge level
	logic [PTR_W-1:0] ptr_q; // register pointer
	logic inc_q; // pointer increment enable
	logic sda_oe_q; // pulling data low
	logic active_q; // transfer in progress
	logic [1:0] asel_s_q; // select pin synchroniser
	logic [2:0] ack_s_q; // read answer toggle sync
	logic [2:0] to_s_q; // timeout toggle sync
	logic [BYTE_W-1:0] rdbuf_q; // last read answer
	logic [BYTE_W-1:0] rdata_q; // read answer, stable for lclk
	logic ack_tgl_q; // read answer toggle, mclk side
	logic to_tgl_q; // timeout toggle, mclk side
	// request bundle towards mclk, held until the next request
	logic req_tgl_q;
	logic x_wr_q;
	logic [PTR_W-1:0] x_addr_q;
	logic [BYTE_W-1:0] x_data_q;
	// decoded events
	logic sof;
	logic eof;
	logic fall;
	logic rise;
	logic abort;
	logic byte_done;
	logic addr_match;
	logic [PTR_W-1:0] ptr_next;

	assign abort = to_s_q[1] ^ to_s_q[2];
	assign sof = lk.start_det;
	assign eof = lk.stop_det | abort;
	// edges never coincide with conditions; guard anyway
	assign fall = lk.scl_fall & ~sof & ~eof;
	assign rise = lk.scl_rise & ~sof & ~eof;
	assign byte_done = cnt_q == BYTE_BITS;
	// [RULE14] compare against the address the pin selects
	assign addr_match = shift_q[BYTE_W-1:1] ==
		(asel_s_q[1] ? SLAVE_ADDR_HI : SLAVE_ADDR_LO);
	// [RULE19] next pointer after an access
	assign ptr_next = inc_q ? PTR_W'(ptr_q + PTR_ONE) : ptr_q;

	// select pin synchroniser, free running
	// [RULE15] present level used, never latched
	always_ff @(posedge lclk or negedge lrst_n)
	begin
		if (!lrst_n)
			asel_s_q <= 2'h0;
		else
			asel_s_q <= {asel_s_q[0], address_select_pin};
	end

	// next state of the engine
	always_comb
	begin
		state_d = state_q;
		// [RULE7] start in any state restarts address reception
		if (sof)
			state_d = ST_ADDR;
		// [RULE8] stop or timeout abandons the transfer
		else if (eof)
			state_d = ST_IDLE;
		else if (fall)
		begin
			case (state_q)
				ST_ADDR:
					// [RULE17] no match: stay off the bus
					if (byte_done)
						state_d = addr_match ? ST_ADDR_ACK : ST_IGNORE;
				ST_ADDR_ACK:
					// [RULE18] write goes on with the pointer byte
					state_d = rw_q ? ST_RDATA : ST_PTR;
				ST_PTR:
					if (byte_done)
						state_d = ST_PTR_ACK;
				ST_PTR_ACK:
					state_d = ST_WDATA;
				ST_WDATA:
					if (byte_done)
						state_d = ST_WACK;
				ST_WACK:
					state_d = ST_WDATA;
				ST_RDATA:
					if (byte_done)
						state_d = ST_RACK;
				ST_RACK:
					// [RULE12] nack ends our sending
					state_d = nack_q ? ST_IGNORE : ST_RDATA;
				default:
					state_d = state_q;
			endcase
		end
	end

	// state register and activity level for the timeout
	always_ff @(posedge lclk or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			state_q <= ST_IDLE;
			active_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			active_q <= state_d != ST_IDLE;
		end
	end

	// bit counter, cleared on every unit boundary
	// [RULE3] eight bits then one acknowledge period
	always_ff @(posedge lclk or negedge lrst_n)
	begin
		if (!lrst_n)
			cnt_q <= 4'h0;
		else if (sof || state_d != state_q)
			cnt_q <= 4'h0;
		else if (rise && !byte_done)
			cnt_q <= cnt_q + CNT_ONE;
	end

	// receive shifter, direction and master acknowledge
	always_ff @(posedge lclk or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			shift_q <= '0;
			rw_q <= 1'b0;
			nack_q <= 1'b1;
		end
		else
		begin
			// [RULE4] sample data on the clock rise
			if (rise && (state_q == ST_ADDR || state_q == ST_PTR ||
				state_q == ST_WDATA))
				shift_q <= {shift_q[BYTE_W-2:0], lk.sda_lvl};
			// [RULE9] direction is the last address bit
			if (fall && state_q == ST_ADDR && byte_done)
				rw_q <= shift_q[RW_BIT];
			// [RULE12] high level in the ack period is nack
			if (rise && state_q == ST_RACK)
				nack_q <= lk.sda_lvl;
		end
	end

	// transmit shifter, loaded when a byte starts
	always_ff @(posedge lclk or negedge lrst_n)
	begin
		if (!lrst_n)
			tx_q <= '0;
		else if (state_d == ST_RDATA && state_q != ST_RDATA)
			tx_q <= rdbuf_q;
		else if (fall && state_q == ST_RDATA && !byte_done)
			tx_q <= {tx_q[BYTE_W-2:0], 1'b0};
	end

	// register pointer; survives stop, start and timeout
	// [RULE20] only pointer bytes and increments change it
	always_ff @(posedge lclk or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			ptr_q <= PTR_RESET;
			inc_q <= 1'b0;
		end
		else if (fall && state_q == ST_PTR && byte_done)
		begin
			// [RULE19] top bit enables increment, low bits select
			ptr_q <= shift_q[PTR_W-1:0];
			inc_q <= shift_q[PTR_INC_BIT];
		end
		else if (fall && (state_q == ST_WACK ||
			(state_q == ST_RDATA && byte_done)))
			ptr_q <= ptr_next;
	end

	// data line drive; only ever pulls low
	// [RULE13] drive only acks of written bytes and read data
	always_ff @(posedge lclk or negedge lrst_n)
	begin
		if (!lrst_n)
			sda_oe_q <= 1'b0;
		else if (sof || eof)
			sda_oe_q <= 1'b0;
		else if (fall)
		begin
			case (state_q)
				// [RULE10] hold the line low through the ninth pulse
				ST_ADDR:
					sda_oe_q <= byte_done && addr_match;
				ST_PTR, ST_WDATA:
					sda_oe_q <= byte_done;
				// [RULE11] first read bit goes out as the ack ends
				ST_ADDR_ACK:
					sda_oe_q <= rw_q && !rdbuf_q[BYTE_W-1];
				// [RULE11] release for the master acknowledge
				ST_RDATA:
					sda_oe_q <= !byte_done && !tx_q[BYTE_W-2];
				ST_RACK:
					sda_oe_q <= !nack_q && !rdbuf_q[BYTE_W-1];
				default:
					sda_oe_q <= 1'b0;
			endcase
		end
	end

	// requests to the register side, one toggle per request
	always_ff @(posedge lclk or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			req_tgl_q <= 1'b0;
			x_wr_q <= 1'b0;
			x_addr_q <= PTR_RESET;
			x_data_q <= '0;
		end
		else if (fall && state_q == ST_ADDR && byte_done && addr_match &&
			shift_q[RW_BIT])
		begin
			// fetch the first read byte during the address ack
			req_tgl_q <= ~req_tgl_q;
			x_wr_q <= 1'b0;
			x_addr_q <= ptr_q;
		end
		else if (fall && state_q == ST_RDATA && byte_done)
		begin
			// prefetch the next byte during the master ack
			req_tgl_q <= ~req_tgl_q;
			x_wr_q <= 1'b0;
			x_addr_q <= ptr_next;
		end
		else if (fall && state_q == ST_WACK)
		begin
			// [RULE16] write issued at the trailing ack edge
			req_tgl_q <= ~req_tgl_q;
			x_wr_q <= 1'b1;
			x_addr_q <= ptr_q;
			x_data_q <= shift_q;
		end
	end

	// answers and timeout from mclk; capture read data on toggle
	always_ff @(posedge lclk or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			ack_s_q <= 3'h0;
			to_s_q <= 3'h0;
			rdbuf_q <= '0;
		end
		else
		begin
			ack_s_q <= {ack_s_q[1:0], ack_tgl_q};
			to_s_q <= {to_s_q[1:0], to_tgl_q};
			if (ack_s_q[1] ^ ack_s_q[2])
				rdbuf_q <= rdata_q;
		end
	end

	// [RULE1] clock line is never driven
	assign scl_o = 1'b0;
	assign scl_oe = 1'b0;
	// [RULE2] open drain: output low, enable pulls
	assign sda_o = 1'b0;
	assign sda_oe = sda_oe_q;

	// ==========================================================
	// register side (mclk)
	logic [2:0] req_s_q; // request toggle sync
	logic reg_wr_q;
	logic reg_rd_q;
	logic [PTR_W-1:0] reg_addr_q;
	logic [BYTE_W-1:0] reg_wdata_q;
	logic mode_start_q;
	logic [MODE_W-1:0] mode_val_q;
	logic req_hit;

	assign req_hit = req_s_q[1] ^ req_s_q[2];

	// take a request; bundle was stable for two mclk edges
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_s_q <= 3'h0;
			reg_wr_q <= 1'b0;
			reg_rd_q <= 1'b0;
			reg_addr_q <= PTR_RESET;
			reg_wdata_q <= '0;
			mode_start_q <= 1'b0;
			mode_val_q <= '0;
		end
		else
		begin
			req_s_q <= {req_s_q[1:0], req_tgl_q};
			reg_wr_q <= req_hit && x_wr_q;
			reg_rd_q <= req_hit && !x_wr_q;
			// [RULE16] new mode takes effect with the write
			mode_start_q <= req_hit && x_wr_q && x_addr_q == MODE_REG_ADDR;
			if (req_hit)
			begin
				reg_addr_q <= x_addr_q;
				reg_wdata_q <= x_data_q;
			end
			if (req_hit && x_wr_q && x_addr_q == MODE_REG_ADDR)
				mode_val_q <= x_data_q[MODE_LSB+MODE_W-1:MODE_LSB];
		end
	end

	// read answer back to the bus side
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_q <= '0;
			ack_tgl_q <= 1'b0;
		end
		else if (reg_rd_q)
		begin
			rdata_q <= reg_rdata;
			ack_tgl_q <= ~ack_tgl_q;
		end
	end

	assign reg_wr = reg_wr_q;
	assign reg_rd = reg_rd_q;
	assign reg_addr = reg_addr_q;
	assign reg_wdata = reg_wdata_q;
	assign mode_start = mode_start_q;
	assign mode_val = mode_val_q;

	// ==========================================================
	// bus idle timeout (mclk)
	logic [2:0] sclm_s_q; // clock line sync
	logic [1:0] act_s_q; // activity level sync
	logic [TO_W-1:0] to_cnt_q;
	logic bus_timeout_q;

	// count cycles with no clock edge during a transfer
	// [RULE8] limit reached: abandon via toggle to lclk
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclm_s_q <= SYNC_IDLE;
			act_s_q <= 2'h0;
			to_cnt_q <= '0;
			to_tgl_q <= 1'b0;
			bus_timeout_q <= 1'b0;
		end
		else
		begin
			sclm_s_q <= {sclm_s_q[1:0], scl_i};
			act_s_q <= {act_s_q[0], active_q};
			bus_timeout_q <= 1'b0;
			if (!act_s_q[1] || sclm_s_q[1] != sclm_s_q[2])
				to_cnt_q <= '0;
			else if (to_cnt_q == TO_W'(TIMEOUT_CYC - 1))
			begin
				to_cnt_q <= '0;
				to_tgl_q <= ~to_tgl_q;
				bus_timeout_q <= 1'b1;
			end
			else
				to_cnt_q <= to_cnt_q + TO_W'(1);
		end
	end

	assign bus_timeout = bus_timeout_q;

	// ==========================================================
	// assertions
	a_start_restart: assert property (@(posedge lclk) disable iff (!lrst_n) // [RULE7]
		sof |=> state_q == ST_ADDR && cnt_q == 4'h0)
		else $error("start did not restart address reception");
	a_stop_idle: assert property (@(posedge lclk) disable iff (!lrst_n) // [RULE6]
		lk.stop_det && !sof |=> state_q == ST_IDLE && !sda_oe_q)
		else $error("stop did not return to idle");
	a_addr_nack: assert property (@(posedge lclk) disable iff (!lrst_n) // [RULE17]
		fall && state_q == ST_ADDR && byte_done && !addr_match
		|=> state_q == ST_IGNORE && !sda_oe_q)
		else $error("foreign address was acknowledged");
	a_addr_ack: assert property (@(posedge lclk) disable iff (!lrst_n) // [RULE10]
		fall && state_q == ST_ADDR && byte_done && addr_match
		|=> sda_oe_q && state_q == ST_ADDR_ACK)
		else $error("own address not acknowledged");
	a_drive_legal: assert property (@(posedge lclk) disable iff (!lrst_n) // [RULE13]
		sda_oe_q |-> state_q inside {ST_ADDR_ACK, ST_PTR_ACK, ST_WACK,
		ST_RDATA})
		else $error("data line driven outside ack or read");
	a_rx_sample: assert property (@(posedge lclk) disable iff (!lrst_n) // [RULE4]
		rise && state_q == ST_PTR |=> shift_q[0] == $past(lk.sda_lvl))
		else $error("received bit not taken on clock rise");
	a_nack_ends: assert property (@(posedge lclk) disable iff (!lrst_n) // [RULE12]
		fall && state_q == ST_RACK && nack_q
		|=> state_q == ST_IGNORE && !sda_oe_q [*2])
		else $error("sending went on after nack");
	a_ptr_inc: assert property (@(posedge lclk) disable iff (!lrst_n) // [RULE19]
		fall && state_q == ST_WACK && inc_q
		|=> ptr_q == PTR_W'($past(ptr_q) + PTR_ONE))
		else $error("pointer did not increment");
	a_ptr_keep: assert property (@(posedge lclk) disable iff (!lrst_n) // [RULE20]
		(sof || eof || (fall && state_q == ST_WACK && !inc_q))
		|=> $stable(ptr_q))
		else $error("pointer changed without increment");
	a_mode_start: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE16]
		mode_start_q |-> reg_wr_q && reg_addr_q == MODE_REG_ADDR
		&& mode_val_q == reg_wdata_q[MODE_LSB+MODE_W-1:MODE_LSB])
		else $error("mode start without mode register write");
	c_mode_write: cover property (@(posedge mclk) disable iff (!rst_n)
		mode_start_q);
	c_read_nack: cover property (@(posedge lclk) disable iff (!lrst_n)
		fall && state_q == ST_RACK && nack_q);
	c_restart: cover property (@(posedge lclk) disable iff (!lrst_n)
		sof && state_q == ST_WDATA);
	c_timeout: cover property (@(posedge mclk) disable iff (!rst_n)
		bus_timeout_q);
endmodule

// >>> aip_master_model.sv
// Purpose: two-wire bus master model driving the slave port's pins.
// Assumes: lines are open drain with pull-ups worked out in the bench.
// Notes:   one quarter bit is ten lclk periods, about 390 kHz.
`timescale 1ns/100ps
module aip_master_model
(
	input wire logic lclk,
	input wire logic sda_i,
	output logic scl_pull,
	output logic sda_pull
);
	// ==========================================================
	// line drive
	// pull flags only: a released line floats up to the pull-up
	// pull or release only
	initial
	begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	// one quarter bit, stepped just after an lclk edge
	task automatic q;
		repeat (10) @(posedge lclk);
		#1;
	endtask
	task automatic bus_start;
		sda_pull = 1'b0;
		q;
		scl_pull = 1'b0;
		q;
		sda_pull = 1'b1;
		q;
		scl_pull = 1'b1;
		q;
	endtask
	task automatic bus_stop;
		sda_pull = 1'b1;
		q;
		scl_pull = 1'b0;
		q;
		sda_pull = 1'b0;
		q;
	endtask
	// master clocks, data set while low
	task automatic bit_io(input logic b, output logic r);
		sda_pull = ~b;
		q;
		scl_pull = 1'b0;
		q;
		r = sda_i;
		q;
		scl_pull = 1'b1;
		q;
	endtask
	task automatic wr(input logic [7:0] d, output logic ack_n);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, ack_n);
	endtask
	task automatic rd(input logic ack_n, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(ack_n, r);
	endtask
endmodule

// >>> adc_monitor_i2c_slave_port_tb_top.sv
// Purpose: self-checking bench of the two-wire slave port.
// Assumes: register file model answers combinationally on the index.
// Notes:   idle limit shortened to 2000 mclk cycles.
`timescale 1ns/100ps
module adc_monitor_i2c_slave_port_tb_top;
	import aip_pkg::*;
	// ==========================================================
	// clocks, pins and counters
	logic mclk = 1'b0;
	logic lclk = 1'b0;
	logic rst_n = 1'b0;
	logic sel = 1'b0;
	logic scl_pull, sda_pull, scl_o, scl_oe, sda_o, sda_oe;
	logic reg_wr, reg_rd, mode_start, bus_timeout;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [5:0] mode_val;
	logic [4:0] wa[$];
	logic [7:0] wd[$];
	int n_fail = 0, n_tests = 0, n_mode = 0, n_to = 0, scl_bad = 0;
	int n_rd = 0;
	// wired-and bus with pull-ups
	wire scl = ~(scl_pull | scl_oe);
	wire sda = ~(sda_pull | sda_oe);
	// register file contents, a fixed pattern per index
	function automatic logic [7:0] rf(input logic [4:0] a);
		return {a, 3'h5} ^ 8'h96;
	endfunction
	initial
	begin
		forever #20 mclk = ~mclk;
	end
	// link clock, unrelated phase
	initial
	begin
		#7;
		forever #32 lclk = ~lclk;
	end
	aip_slave_port #(.TIMEOUT_CYC(2000)) uut (.mclk(mclk), .rst_n(rst_n),
		.lclk(lclk), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.address_select_pin(sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(rf(reg_addr)), .mode_start(mode_start),
		.mode_val(mode_val), .bus_timeout(bus_timeout));
	aip_master_model mdl (.lclk(lclk), .sda_i(sda), .scl_pull(scl_pull),
		.sda_pull(sda_pull));
	// ==========================================================
	// monitor of register-side pulses
	always @(posedge mclk)
	begin
		if (reg_wr === 1'b1)
		begin
			wa.push_back(reg_addr);
			wd.push_back(reg_wdata);
		end
		if (mode_start === 1'b1)
			n_mode++;
		if (bus_timeout === 1'b1)
			n_to++;
		if (reg_rd === 1'b1)
			n_rd++;
		// clock never driven, data only pulled low
		if (scl_oe !== 1'b0 || scl_o !== 1'b0 || sda_o !== 1'b0)
			scl_bad++;
	end
	// ==========================================================
	// checking and closing
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	// pointer with increment, then two data bytes to index 0 and 1
	task automatic do_write;
		logic a;
		mdl.bus_start;
		mdl.wr({7'b1001000, 1'b0}, a);
		chk(a, 0);
		mdl.wr(8'h80, a);
		chk(a, 0);
		mdl.wr(8'ha4, a);
		chk(a, 0);
		mdl.wr(8'h5b, a);
		chk(a, 0);
		mdl.bus_stop;
		repeat (20) @(posedge mclk);
		chk(8'(wa.size()), 2);
		chk({3'h0, wa[0]}, 0);
		chk(wd[0], 8'ha4);
		chk({3'h0, wa[1]}, 1);
		chk(wd[1], 8'h5b);
		chk({2'h0, mode_val}, 8'ha4 >> 2);
		chk(8'(n_mode), 1);
	endtask
	// read without a new pointer, increment still on
	task automatic do_read;
		logic a;
		logic [7:0] d;
		mdl.bus_start;
		mdl.wr({7'b1001000, 1'b1}, a);
		chk(a, 0);
		mdl.rd(1'b0, d);
		chk(d, rf(5'h02));
		mdl.rd(1'b1, d);
		chk(d, rf(5'h03));
		chk({7'h0, sda_oe}, 0);
		mdl.bus_stop;
		repeat (20) @(posedge mclk);
		// one fetch per sent byte plus the prefetch after the last
		chk(8'(n_rd), 3);
	endtask
	// wrong address ignored, then select pin high and repeated starts
	task automatic do_sel;
		logic a;
		logic [7:0] d;
		mdl.bus_start;
		mdl.wr({7'b1001001, 1'b0}, a);
		chk(a, 1);
		mdl.wr(8'h05, a);
		chk(a, 1);
		@(posedge mclk);
		#1 sel = 1'b1;
		mdl.bus_start;
		mdl.wr({7'b1001001, 1'b0}, a);
		chk(a, 0);
		mdl.wr(8'h05, a);
		chk(a, 0);
		mdl.bus_start;
		mdl.wr({7'b1001001, 1'b1}, a);
		chk(a, 0);
		mdl.rd(1'b0, d);
		chk(d, rf(5'h05));
		mdl.rd(1'b1, d);
		chk(d, rf(5'h05));
		mdl.bus_stop;
		@(posedge mclk);
		#1 sel = 1'b0;
		chk(8'(wa.size()), 2);
		chk(8'(n_rd), 6);
	endtask
	// stall mid-transfer until the idle limit abandons it
	task automatic do_tmo;
		logic a;
		int i;
		mdl.bus_start;
		mdl.wr({7'b1001000, 1'b0}, a);
		mdl.wr(8'h03, a);
		i = 0;
		while (n_to == 0 && i < 3000)
		begin
			@(posedge mclk);
			i++;
		end
		chk(8'(n_to), 1);
		if (i == 3000)
			finish_test;
		repeat (10) @(posedge mclk);
		chk({7'h0, sda_oe}, 0);
		mdl.wr(8'h77, a);
		chk(a, 1);
		mdl.bus_stop;
		repeat (20) @(posedge mclk);
		chk(8'(wa.size()), 2);
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial
	begin
		repeat (2) @(posedge mclk);
		#1 rst_n = 1'b1;
		repeat (10) @(posedge mclk);
		do_write;
		do_read;
		do_sel;
		do_tmo;
		chk(8'(scl_bad), 0);
		finish_test;
	end
	initial
	begin
		repeat (100000) @(posedge mclk);
		n_fail++;
		finish_test;
	end
endmodule
